// ### common/hcp_pkg.sv
// hcp_pkg: constants for the host-side controller of the parallel cpu port.
// assumes one 100 MHz clock and a device that pulls cycle_done_n low to finish each access.
package hcp_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // bus width strap encodings
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam int unsigned WIDTH_32_BIT = 1;
  // default wait for cycle_done_n before giving up, in ns
  localparam int unsigned DONE_TIMEOUT_NS = 10000;
  localparam int unsigned DONE_TIMEOUT_CYC = DONE_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] LANE_0 = 2'h0;
  localparam logic [1:0] LANE_1 = 2'h1;
  localparam logic [1:0] LANE_2 = 2'h2;
  localparam logic [1:0] LANE_3 = 2'h3;
  localparam int unsigned HALF_HI_BIT = 1;
  typedef enum logic [1:0] {HCP_ST_IDLE, HCP_ST_STROBE, HCP_ST_RELEASE, HCP_ST_NEXT} hcp_state_e;
endpackage : hcp_pkg

// ### design/hcp_lane_map.sv
// hcp_lane_map: works out how many pins-wide beats an access takes in the strapped width.
// assumes bus_width_sel is static during an access.
`timescale 1ns/1ps
module hcp_lane_map (
  input  wire logic [1:0] bus_width_sel, // width strap
  input  wire logic [1:0] beat_idx,      // which beat of the word
  output logic      [1:0] beat_last,     // index of the final beat
  output logic      [1:0] lane_sel       // byte_lane_sel for this beat
);
  always_comb begin
    if (bus_width_sel == hcp_pkg::WIDTH_8) begin
      beat_last = hcp_pkg::LANE_3;
      lane_sel  = beat_idx;
    end else if (bus_width_sel == hcp_pkg::WIDTH_16) begin
      beat_last = hcp_pkg::LANE_1;
      lane_sel  = {beat_idx[0], 1'b0};
    end else begin
      beat_last = hcp_pkg::LANE_0;
      lane_sel  = hcp_pkg::LANE_0;
    end
  end
endmodule : hcp_lane_map

// ### design/hcp_host_ctrl.sv
// hcp_host_ctrl: host controller that drives the device's parallel cpu port.
// a user request moves one 32-bit register word, split into 1, 2 or 4 beats per strap.
// assumes an external pull-up on cycle_done_n and that the data bus is resolved outside.
`timescale 1ns/1ps
// Functional notes
// - the host drives the eleven-bit word address on the address pins for every access.
// - the width strap selects 8-bit for 00, 16-bit for 01 and 32-bit whenever the upper bit is set.
// - data moves on bits 31:0, 15:0 or 7:0 according to width, with higher lanes unused.
// - in 16-bit mode byte-lane select bit one picks the half-word being moved.
// - an access counts only while chip select is held low.
// - a write is marked by the write strobe low, during which data is held on the bus.
// - a read is marked by the read strobe low, and data is returned during it.
module hcp_host_ctrl #(
  parameter int unsigned TIMEOUT_CYC = hcp_pkg::DONE_TIMEOUT_CYC
) (
  input  wire logic        core_clk,        // 100 MHz clock
  input  wire logic        arst_n,          // async reset, active low
  input  wire logic        req_valid,       // user request, one-cycle pulse while idle
  input  wire logic        req_write,       // 1 write, 0 read
  input  wire logic [10:0] req_addr,        // register word address
  input  wire logic [31:0] req_wdata,       // write word
  output logic             req_busy,        // access in progress
  output logic             rsp_valid,       // one-cycle completion pulse
  output logic [31:0]      rsp_rdata,       // read word
  output logic             rsp_timeout,     // with rsp_valid: device did not answer at least one beat
  input  wire logic [1:0]  bus_width_sel,   // width strap, also wired to the device
  output logic [10:0]      host_word_addr,  // address pins
  output logic [1:0]       byte_lane_sel,   // byte-lane select pins
  output logic [31:0]      host_data_out,   // data bus, host drive value
  output logic             host_data_oe,    // data bus, host drives when high
  input  wire logic [31:0] host_data_in,    // data bus, sampled level
  output logic             chip_sel_n,      // chip select, active low
  output logic             write_strobe_n,  // write strobe, active low
  output logic             read_strobe_n,   // read strobe, active low
  input  wire logic        cycle_done_n     // resolved cycle-complete line, active low
);
  localparam int unsigned TMO_W = $clog2(TIMEOUT_CYC + 1);

  // the compare against TIMEOUT_CYC-1 and the zero reload need at least two counts
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("hcp_host_ctrl: TIMEOUT_CYC must be at least 2");
  end

  hcp_pkg::hcp_state_e state_reg;
  logic [1:0]          beat_reg;
  logic                write_reg;
  logic [31:0]         word_reg;
  logic [TMO_W-1:0]    tmo_reg;
  logic [1:0]          beat_last;
  logic [1:0]          lane_sel;
  logic [1:0]          lane_next;
  logic [31:0]         merged;
  logic [31:0]         beat_wdata;
  logic                done_seen;
  logic                timed_out;
  logic [1:0]          beat_idx;
  logic                last_beat_end;

  // start of the next beat uses the next lane; beat 0 on a fresh request
  hcp_lane_map u_lane_map (
    .bus_width_sel (bus_width_sel),
    .beat_idx      (beat_idx),
    .beat_last     (beat_last),
    .lane_sel      (lane_sel)
  );

  assign lane_next = lane_sel;
  assign done_seen = !cycle_done_n;
  assign timed_out = (tmo_reg == TMO_W'(TIMEOUT_CYC - 1));
  assign last_beat_end = (state_reg == hcp_pkg::HCP_ST_NEXT && beat_reg == beat_last);

  // byte_lane_sel is loaded in NEXT, one cycle before the strobe, so it must already
  // show the lane of the coming beat; otherwise the pins lag the data by one beat
  always_comb begin
    beat_idx = beat_reg;
    if (state_reg == hcp_pkg::HCP_ST_IDLE) begin
      beat_idx = hcp_pkg::LANE_0;
    end else if (state_reg == hcp_pkg::HCP_ST_NEXT) begin
      beat_idx = beat_reg + 2'h1;
    end
  end

  // place the selected beat in the low lanes, upper lanes parked at zero
  always_comb begin
    beat_wdata = 32'h0000_0000;
    if (bus_width_sel[hcp_pkg::WIDTH_32_BIT]) begin
      beat_wdata = word_reg;
    end else if (bus_width_sel == hcp_pkg::WIDTH_16) begin
      beat_wdata[15:0] = lane_sel[hcp_pkg::HALF_HI_BIT] ? word_reg[31:16] : word_reg[15:0];
    end else begin
      beat_wdata[7:0] = word_reg[8*lane_sel +: 8];
    end
  end

  // fold a read beat into the assembled word
  always_comb begin
    merged = word_reg;
    if (bus_width_sel[hcp_pkg::WIDTH_32_BIT]) begin
      merged = host_data_in;
    end else if (bus_width_sel == hcp_pkg::WIDTH_16) begin
      merged[16*lane_sel[hcp_pkg::HALF_HI_BIT] +: 16] = host_data_in[15:0];
    end else begin
      merged[8*lane_sel +: 8] = host_data_in[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= hcp_pkg::HCP_ST_IDLE;
      beat_reg  <= 2'h0;
      write_reg <= 1'b0;
      word_reg  <= 32'h0000_0000;
      tmo_reg   <= '0;
    end else begin
      unique case (state_reg)
        hcp_pkg::HCP_ST_IDLE: begin
          beat_reg <= 2'h0;
          tmo_reg  <= '0;
          if (req_valid) begin
            write_reg <= req_write;
            word_reg  <= req_write ? req_wdata : 32'h0000_0000;
            state_reg <= hcp_pkg::HCP_ST_STROBE;
          end
        end
        hcp_pkg::HCP_ST_STROBE: begin
          // hold everything until the device answers; a stuck line is cut off by the timer
          tmo_reg <= tmo_reg + 1'b1;
          if (done_seen || timed_out) begin
            if (!write_reg && done_seen) word_reg <= merged;
            state_reg <= hcp_pkg::HCP_ST_RELEASE;
          end
        end
        hcp_pkg::HCP_ST_RELEASE: begin
          // wait for the device to release cycle_done_n before any new strobe
          tmo_reg <= '0;
          if (!done_seen) begin
            state_reg <= hcp_pkg::HCP_ST_NEXT;
          end
        end
        hcp_pkg::HCP_ST_NEXT: begin
          if (beat_reg == beat_last) begin
            state_reg <= hcp_pkg::HCP_ST_IDLE;
          end else begin
            beat_reg  <= beat_reg + 2'h1;
            state_reg <= hcp_pkg::HCP_ST_STROBE;
          end
        end
      endcase
    end
  end

  // timeout flag is sticky over the remaining beats of one request
  logic tmo_flag_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_flag_reg <= 1'b0;
    end else if (state_reg == hcp_pkg::HCP_ST_IDLE) begin
      tmo_flag_reg <= 1'b0;
    end else if (state_reg == hcp_pkg::HCP_ST_STROBE && timed_out && !done_seen) begin
      tmo_flag_reg <= 1'b1;
    end
  end

  // pin drive: registered, strobes open only in the strobe state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_word_addr <= 11'h000;
      byte_lane_sel  <= 2'h0;
      host_data_out  <= 32'h0000_0000;
      host_data_oe   <= 1'b0;
      chip_sel_n     <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
    end else begin
      if (state_reg == hcp_pkg::HCP_ST_IDLE && req_valid) begin
        host_word_addr <= req_addr;
      end
      if (state_reg == hcp_pkg::HCP_ST_IDLE || state_reg == hcp_pkg::HCP_ST_NEXT) begin
        byte_lane_sel <= lane_next;
      end
      host_data_out  <= beat_wdata;
      // drive ends with the request, so a strap change after rsp_valid never meets a driven bus
      host_data_oe   <= write_reg && state_reg != hcp_pkg::HCP_ST_IDLE && !last_beat_end;
      chip_sel_n     <= !(state_reg == hcp_pkg::HCP_ST_STROBE && !(done_seen || timed_out));
      write_strobe_n <= !(state_reg == hcp_pkg::HCP_ST_STROBE && write_reg && !(done_seen || timed_out));
      read_strobe_n  <= !(state_reg == hcp_pkg::HCP_ST_STROBE && !write_reg && !(done_seen || timed_out));
    end
  end

  // user side answers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_busy    <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= 32'h0000_0000;
      rsp_timeout <= 1'b0;
    end else begin
      req_busy    <= (state_reg != hcp_pkg::HCP_ST_IDLE && !(state_reg == hcp_pkg::HCP_ST_NEXT && beat_reg == beat_last))
                     || (state_reg == hcp_pkg::HCP_ST_IDLE && req_valid);
      rsp_valid   <= state_reg == hcp_pkg::HCP_ST_NEXT && beat_reg == beat_last;
      if (state_reg == hcp_pkg::HCP_ST_NEXT && beat_reg == beat_last) begin
        rsp_rdata   <= write_reg ? 32'h0000_0000 : word_reg;
        rsp_timeout <= tmo_flag_reg;
      end
    end
  end
endmodule : hcp_host_ctrl

// ### verif/hcp_dev_model.sv
// hcp_dev_model: behavioural register device behind the parallel cpu port.
// assumes cycle_done_n = ~done_pull with a pull-up; sixteen words, decoded on host_word_addr[3:0].
`timescale 1ns/1ps
module hcp_dev_model (
  input  wire logic        clk,           // bench clock
  input  wire logic [1:0]  width,         // strap
  input  wire logic [10:0] addr,          // word address pins
  input  wire logic [1:0]  lane,          // byte lane select
  input  wire logic [31:0] din,           // resolved data bus
  output logic      [31:0] dout,          // device drive value
  output logic             dout_oe,       // device drives bus
  input  wire logic        cs_n,          // chip select
  input  wire logic        wr_n,          // write strobe
  input  wire logic        rd_n,          // read strobe
  output logic             done_pull,     // sinks cycle_done_n
  input  wire logic [3:0]  delay,         // answer latency in cycles
  input  wire logic        mute           // never answer
);
  logic [31:0] mem [16];
  logic [31:0] w, m, s;
  logic [3:0]  cnt;
  assign w = mem[addr[3:0]];
  assign dout_oe = !cs_n && !rd_n;
  // released bus shows a pattern that flips on every clock edge, never a stale value
  assign dout = dout_oe ? s : 32'ha5a5_5a5a ^ {32{clk}};
  always_comb begin
    m = din;
    s = w;
    if (width == 2'h0) begin
      m = w;
      m[8*lane +: 8] = din[7:0];
      s = {24'h00_0000, w[8*lane +: 8]};
    end else if (!width[1]) begin
      m = w;
      m[16*lane[1] +: 16] = din[15:0];
      s = {16'h0000, w[16*lane[1] +: 16]};
    end
  end
  always_ff @(posedge clk) begin
    if (cs_n || (wr_n && rd_n)) begin
      cnt <= 4'h0;
      done_pull <= 1'b0;
    end else if (cnt < delay) begin
      cnt <= cnt + 4'h1;
    end else if (!mute && !done_pull) begin
      done_pull <= 1'b1;
      if (!wr_n) mem[addr[3:0]] <= m;
    end
  end
endmodule : hcp_dev_model

// ### verif/hcp_host_ctrl_properties.sv
// hcp_host_ctrl_properties: pin timing checks on the host controller.
// assumes the bound module's port names.
`timescale 1ns/1ps
module hcp_host_ctrl_chk #(
  parameter int unsigned TIMEOUT_CYC = hcp_pkg::DONE_TIMEOUT_CYC
) (
  input wire logic        core_clk,       // clock
  input wire logic        arst_n,         // async reset, active low
  input wire logic        req_valid,      // user request
  input wire logic        req_busy,       // access in progress
  input wire logic        rsp_valid,      // completion pulse
  input wire logic        cycle_done_n,   // resolved done line
  input wire logic        chip_sel_n,     // chip select
  input wire logic        write_strobe_n, // write strobe
  input wire logic        read_strobe_n,  // read strobe
  input wire logic        host_data_oe,   // host drives data bus
  input wire logic [10:0] req_addr,       // requested address
  input wire logic [10:0] host_word_addr, // address pins
  input wire logic [1:0]  bus_width_sel,  // width strap
  input wire logic [1:0]  byte_lane_sel,  // lane pins
  input wire logic [31:0] host_data_out   // write data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  int unsigned low_cnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) low_cnt <= 0;
    else low_cnt <= chip_sel_n ? 0 : low_cnt + 1;
  end
  chk_cs_frames_strobe: assert property ((!write_strobe_n || !read_strobe_n) |-> !chip_sel_n)
    else $error("strobe low without chip select");
  chk_one_strobe: assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("both strobes low");
  chk_no_drive_read: assert property (!read_strobe_n |-> !host_data_oe)
    else $error("host drives bus during read");
  chk_addr_taken: assert property (req_valid && !req_busy |=> host_word_addr == $past(req_addr))
    else $error("address pins not set from request");
  chk_pins_hold: assert property (!chip_sel_n ##1 !chip_sel_n |->
    $stable(host_word_addr) && $stable(byte_lane_sel) && $stable(host_data_out))
    else $error("pins moved during access");
  chk_end_on_done: assert property (!chip_sel_n && !cycle_done_n |=>
    chip_sel_n && write_strobe_n && read_strobe_n)
    else $error("access not ended after done");
  chk_wide_lanes: assert property (!chip_sel_n && bus_width_sel[1] |-> byte_lane_sel == hcp_pkg::LANE_0)
    else $error("lane select in 32-bit mode");
  chk_half_lanes: assert property (!chip_sel_n && bus_width_sel == hcp_pkg::WIDTH_16 |-> !byte_lane_sel[0])
    else $error("odd lane in 16-bit mode");
  chk_byte_unused: assert property (host_data_oe && bus_width_sel == hcp_pkg::WIDTH_8 |->
    host_data_out[31:8] == 0)
    else $error("upper lanes driven in 8-bit mode");
  chk_wait_bound: assert property (low_cnt <= TIMEOUT_CYC + 2)
    else $error("strobe held past timeout");
  cov_write: cover property (!write_strobe_n && !cycle_done_n);
  cov_read: cover property (!read_strobe_n && !cycle_done_n);
  cov_byte: cover property (!chip_sel_n && byte_lane_sel == hcp_pkg::LANE_3);
  cov_half_hi: cover property (!chip_sel_n && bus_width_sel == hcp_pkg::WIDTH_16 && byte_lane_sel[1]);
endmodule : hcp_host_ctrl_chk
bind hcp_host_ctrl hcp_host_ctrl_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .core_clk       (core_clk),
  .arst_n         (arst_n),
  .req_valid      (req_valid),
  .req_busy       (req_busy),
  .rsp_valid      (rsp_valid),
  .cycle_done_n   (cycle_done_n),
  .chip_sel_n     (chip_sel_n),
  .write_strobe_n (write_strobe_n),
  .read_strobe_n  (read_strobe_n),
  .host_data_oe   (host_data_oe),
  .req_addr       (req_addr),
  .host_word_addr (host_word_addr),
  .bus_width_sel  (bus_width_sel),
  .byte_lane_sel  (byte_lane_sel),
  .host_data_out  (host_data_out)
);

// ### verif/test_host_cpu_port.sv
// test_host_cpu_port: host controller against the register device model.
// assumes a pull-up on the done line; TIMEOUT_CYC shortened to 8.
`timescale 1ns/1ps
module test_host_cpu_port;
  logic core_clk = 0, arst_n = 0, req_valid = 0, req_write = 0, mute = 0;
  logic req_busy, rsp_valid, rsp_timeout, h_oe, d_oe, cs_n, wr_n, rd_n, pull, tmo;
  logic [10:0] req_addr = '0, host_word_addr;
  logic [31:0] req_wdata = '0, rsp_rdata, h_out, d_out, bus, rd;
  logic [1:0]  bus_width_sel = 2'h3, byte_lane_sel;
  logic [3:0]  delay = 4'h0;
  int error_cnt = 0, checks = 0;
  assign bus = h_oe ? h_out : d_out;
  initial forever #5 core_clk = ~core_clk;
  hcp_host_ctrl #(.TIMEOUT_CYC(8)) dut (.core_clk, .arst_n, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_busy, .rsp_valid, .rsp_rdata, .rsp_timeout, .bus_width_sel, .host_word_addr, .byte_lane_sel,
    .host_data_out(h_out), .host_data_oe(h_oe), .host_data_in(bus), .chip_sel_n(cs_n),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .cycle_done_n(~pull));
  hcp_dev_model u_dev (.clk(core_clk), .width(bus_width_sel), .addr(host_word_addr), .lane(byte_lane_sel),
    .din(bus), .dout(d_out), .dout_oe(d_oe), .cs_n, .wr_n, .rd_n, .done_pull(pull), .delay, .mute);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // host and device must never drive the data bus at once
  always @(negedge core_clk) begin
    if (h_oe === 1'b1 && d_oe === 1'b1) chk("bus_contention", 32'(d_oe), 0);
  end
  task automatic xfer(logic w, logic [10:0] a, logic [31:0] d);
    @(negedge core_clk);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req_valid = 0;
    chk("busy_set", 32'(req_busy), 1);
    for (int i = 0; i < 300 && rsp_valid !== 1'b1; i++) @(negedge core_clk);
    chk("rsp_valid", 32'(rsp_valid), 1);
    chk("busy_end", 32'(req_busy), 0);
    rd = rsp_rdata;
    tmo = rsp_timeout;
  endtask : xfer
  // write in each strap, read back in the next one so lane splitting must agree both ways
  task automatic t_widths;
    for (int m = 0; m < 4; m++) begin
      bus_width_sel = m[1:0];
      delay = 4'(m + 2);
      xfer(1, 11'(m * 3 + 1025), 32'h1234_5678 ^ {8{m[3:0]}});
      chk("wr_timeout", 32'(tmo), 0);
      chk("wr_rdata", rd, 32'h0000_0000);
      bus_width_sel = 2'(m + 1);
      xfer(0, 11'(m * 3 + 1025), 32'h0000_0000);
      chk("rd_word", rd, 32'h1234_5678 ^ {8{m[3:0]}});
    end
  endtask : t_widths
  // silent device: the write is abandoned and the stored word survives
  task automatic t_abort;
    bus_width_sel = 2'h0;
    mute = 1;
    xfer(1, 11'h0401, 32'hdead_beef);
    chk("abort_flag", 32'(tmo), 1);
    mute = 0;
    xfer(0, 11'h0401, 32'h0000_0000);
    chk("kept_word", rd, 32'h1234_5678);
  endtask : t_abort
  task automatic results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1;
    t_widths;
    t_abort;
    results;
  end
  initial begin
    #50us;
    error_cnt++;
    results;
  end
endmodule : test_host_cpu_port
